// ===== include/dcf_pkg.sv
// shared constants and carrier types of the dual-clock fifo flag block
package dcf_pkg;

   // ==========================================================
   // data path and depth
   localparam int          DATA_W        = 9;
   localparam int          DEPTH_DEFAULT = 16384;
   localparam int          BUS_AW        = 8;

   // ==========================================================
   // skew margins in ns, faster grade
   localparam int          SKEW1_NS      = 5;
   localparam int          SKEW2_NS      = 10;

   // ==========================================================
   // register offsets
   localparam logic [7:0]  OFS_STATUS    = 8'h00;
   localparam logic [7:0]  OFS_EMPTY_OFF = 8'h04;
   localparam logic [7:0]  OFS_FULL_OFF  = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_CLR   = 8'h10;
   localparam logic [7:0]  OFS_IRQ_EN    = 8'h14;
   localparam logic [7:0]  OFS_LEVEL     = 8'h18;

   // ==========================================================
   // status register fields
   localparam int          ST_EMPTY_N    = 0;
   localparam int          ST_FULL_N     = 1;
   localparam int          ST_AEMPTY_N   = 2;
   localparam int          ST_AFULL_N    = 3;
   localparam int          ST_MODE_WE2   = 4;

   // ==========================================================
   // interrupt event bits
   localparam int          IRQ_W         = 4;
   localparam int          EV_OVERFLOW   = 0;
   localparam int          EV_UNDERFLOW  = 1;
   localparam int          EV_NOT_EMPTY  = 2;
   localparam int          EV_FULL       = 3;

   // ==========================================================
   // reset values
   localparam logic [16:0] OFFSET_RST    = 17'h00007;
   localparam logic [3:0]  IRQ_EN_RST    = 4'h0;

   // ==========================================================
   // types
   typedef struct packed {
      logic              write_enable_first_n;
      logic              write_enable_second_or_offset_load;
      logic              read_enable_first_n;
      logic              read_enable_second_n;
      logic              output_enable_n;
      logic [DATA_W-1:0] write_data_bus;
   } dcf_pins_t;

   typedef struct packed {
      logic almost_full_flag_n;
      logic almost_empty_flag_n;
      logic full_flag_n;
      logic empty_flag_n;
   } dcf_flags_t;

   typedef enum logic [1:0] {
      LD_EMPTY = 2'b01,
      LD_FULL  = 2'b10
   } dcf_ld_sel_t;

endpackage

// ===== logic/dcf_sync.sv
// two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
module dcf_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] d,
   output      logic [W-1:0] q
);

   // ==========================================================
   // stages
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // no reset: pins settle while reset is held with clocks running
   always_ff @(posedge clk)
   begin
      meta_reg <= d;
      sync_reg <= meta_reg;
   end

   assign q = sync_reg;

endmodule

// ===== logic/dcf_mem.sv
// storage array with registered read data
`timescale 1ns/1ps
module dcf_mem #(
   parameter int W     = 9,
   parameter int DEPTH = 16384
) (
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [W-1:0]             wr_data,
   input  wire logic                     rd_en,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output      logic [W-1:0]             rd_data
);

   // ==========================================================
   // array
   logic [W-1:0] mem [DEPTH];
   logic [W-1:0] rd_data_reg;
   logic [W-1:0] rd_data_next;

   always_ff @(posedge clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // ==========================================================
   // read register, cleared by reset so data pins read low
   always_comb
   begin
      rd_data_next = rd_en ? mem[rd_addr] : rd_data_reg;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_data_reg <= '0;
      end
      else
      begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;

endmodule

// ===== logic/dcf_top.sv
// fifo with empty, full and programmable almost flags
// Functional notes
// - read frees full flag next write edge
// - write clears empty flag next read edge
// - clocks may run during reset
// - after reset data low, or released by output enable
// - strap at reset picks second enable or load
// - first word comes cycle after empty lifts
// - first-word latency only from empty buffer
// - almost-empty lags one read edge on skew
// - almost-full lags one write edge on skew
// - read at almost-empty edge leaves offset words
// - write at almost-full edge leaves threshold words
// - depth is a parameter, threshold depth minus offset
// - first skew margin five nanoseconds
// - second skew margin ten nanoseconds
// - almost-empty low at or below empty offset
// - almost-full low at or above depth minus offset
`timescale 1ns/1ps
module dcf_top #(
   parameter int DEPTH = dcf_pkg::DEPTH_DEFAULT
) (
   input  wire logic                        CLK,
   input  wire logic                        SRST,
   input  wire logic                        WRITE_ENABLE_FIRST_N,
   input  wire logic                        WRITE_ENABLE_SECOND_OR_OFFSET_LOAD,
   input  wire logic                        READ_ENABLE_FIRST_N,
   input  wire logic                        READ_ENABLE_SECOND_N,
   input  wire logic                        OUTPUT_ENABLE_N,
   input  wire logic [dcf_pkg::DATA_W-1:0]  WRITE_DATA_BUS,
   output      logic [dcf_pkg::DATA_W-1:0]  READ_DATA_BUS,
   output      logic                        READ_DATA_BUS_OE,
   output      logic                        EMPTY_FLAG_N,
   output      logic                        FULL_FLAG_N,
   output      logic                        ALMOST_EMPTY_FLAG_N,
   output      logic                        ALMOST_FULL_FLAG_N,
   input  wire logic [dcf_pkg::BUS_AW-1:0]  ADDR,
   input  wire logic [31:0]                 WDATA,
   input  wire logic                        WE,
   input  wire logic                        RE,
   output      logic [31:0]                 RDATA,
   output      logic                        IRQ
);

   localparam int             AW      = $clog2(DEPTH);
   localparam logic [AW:0]    DEPTH_C = (AW+1)'(DEPTH);

   // ==========================================================
   // helpers
   function automatic logic [AW:0] level(input logic [AW:0] wp, input logic [AW:0] rp);
      level = wp - rp;
   endfunction

   function automatic logic [31:0] widen(input logic [AW:0] v);
      widen = 32'(v);
   endfunction

   // ==========================================================
   // pin synchronisers
   dcf_pkg::dcf_pins_t pins_raw;
   dcf_pkg::dcf_pins_t pins_s;

   assign pins_raw = '{write_enable_first_n:               WRITE_ENABLE_FIRST_N,
                       write_enable_second_or_offset_load: WRITE_ENABLE_SECOND_OR_OFFSET_LOAD,
                       read_enable_first_n:                READ_ENABLE_FIRST_N,
                       read_enable_second_n:               READ_ENABLE_SECOND_N,
                       output_enable_n:                    OUTPUT_ENABLE_N,
                       write_data_bus:                     WRITE_DATA_BUS};

   dcf_sync #(
      .W ($bits(dcf_pkg::dcf_pins_t))
   ) u_sync (
      .clk (CLK),
      .d   (pins_raw),
      .q   (pins_s)
   );

   // ==========================================================
   // state
   logic                         mode_we2_reg,  mode_we2_next;
   logic [AW:0]                  wptr_reg,      wptr_next;
   logic [AW:0]                  rptr_reg,      rptr_next;
   logic [AW:0]                  wseen_reg,     wseen_next;
   logic [AW:0]                  rseen_reg,     rseen_next;
   dcf_pkg::dcf_flags_t          flags_reg,     flags_next;
   logic [AW-1:0]                eoff_reg,      eoff_next;
   logic [AW-1:0]                foff_reg,      foff_next;
   dcf_pkg::dcf_ld_sel_t         ldsel_reg,     ldsel_next;
   logic [dcf_pkg::IRQ_W-1:0]    istat_reg,     istat_next;
   logic [dcf_pkg::IRQ_W-1:0]    ien_reg,       ien_next;
   logic                         irq_reg,       irq_next;
   logic [31:0]                  rdata_reg,     rdata_next;
   logic                         q_oe_reg,      q_oe_next;

   logic                         wr_req;
   logic                         ld_req;
   logic                         rd_req;
   logic                         wr_ok;
   logic                         rd_ok;
   logic [AW:0]                  wlevel;
   logic [AW:0]                  rlevel;
   logic [AW:0]                  wlevel_next;
   logic [AW:0]                  rlevel_next;
   logic [dcf_pkg::IRQ_W-1:0]    ev;

   // ==========================================================
   // next-state logic
   always_comb
   begin
      // write when first enable low and shared pin high, in either role
      wr_req = ~pins_s.write_enable_first_n & pins_s.write_enable_second_or_offset_load;
      ld_req = ~mode_we2_reg & ~pins_s.write_enable_first_n
               & ~pins_s.write_enable_second_or_offset_load;
      rd_req = ~pins_s.read_enable_first_n & ~pins_s.read_enable_second_n;

      // writer sees reads one edge late, reader sees writes one edge late
      wlevel = level(wptr_reg, rseen_reg);
      rlevel = level(wseen_reg, rptr_reg);
      wr_ok  = wr_req & (wlevel != DEPTH_C);
      rd_ok  = rd_req & (rlevel != '0);

      wptr_next  = wr_ok ? wptr_reg + 1'b1 : wptr_reg;
      rptr_next  = rd_ok ? rptr_reg + 1'b1 : rptr_reg;
      // same-edge clocks never meet the skew margin, so crossing waits one edge
      wseen_next = wptr_reg;
      rseen_next = rptr_reg;
      wlevel_next = level(wptr_next, rseen_next);
      rlevel_next = level(wseen_next, rptr_next);

      flags_next.empty_flag_n        = (rlevel_next != '0);
      flags_next.full_flag_n         = (wlevel_next != DEPTH_C);
      flags_next.almost_empty_flag_n = (rlevel_next > {1'b0, eoff_reg});
      flags_next.almost_full_flag_n  = (wlevel_next < (DEPTH_C - {1'b0, foff_reg}));

      // strap caught while reset is held
      mode_we2_next = SRST ? pins_s.write_enable_second_or_offset_load : mode_we2_reg;

      eoff_next  = eoff_reg;
      foff_next  = foff_reg;
      ldsel_next = ldsel_reg;
      // pin load wins over a bus write in the same cycle
      if (ld_req)
      begin
         unique case (ldsel_reg)
            dcf_pkg::LD_EMPTY:
            begin
               eoff_next  = AW'(pins_s.write_data_bus);
               ldsel_next = dcf_pkg::LD_FULL;
            end
            dcf_pkg::LD_FULL:
            begin
               foff_next  = AW'(pins_s.write_data_bus);
               ldsel_next = dcf_pkg::LD_EMPTY;
            end
            default:
            begin
               ldsel_next = dcf_pkg::LD_EMPTY;
            end
         endcase
      end
      else if (WE && ADDR == dcf_pkg::OFS_EMPTY_OFF)
      begin
         eoff_next = WDATA[AW-1:0];
      end
      else if (WE && ADDR == dcf_pkg::OFS_FULL_OFF)
      begin
         foff_next = WDATA[AW-1:0];
      end

      ev = '0;
      ev[dcf_pkg::EV_OVERFLOW]  = wr_req & ~wr_ok;
      ev[dcf_pkg::EV_UNDERFLOW] = rd_req & ~rd_ok;
      ev[dcf_pkg::EV_NOT_EMPTY] = flags_next.empty_flag_n & ~flags_reg.empty_flag_n;
      ev[dcf_pkg::EV_FULL]      = ~flags_next.full_flag_n & flags_reg.full_flag_n;

      ien_next   = (WE && ADDR == dcf_pkg::OFS_IRQ_EN) ? WDATA[dcf_pkg::IRQ_W-1:0] : ien_reg;
      // set wins over a clear in the same cycle
      istat_next = ev | (istat_reg & ~((WE && ADDR == dcf_pkg::OFS_IRQ_CLR) ?
                                       WDATA[dcf_pkg::IRQ_W-1:0] : '0));
      irq_next   = |(istat_next & ien_next);

      rdata_next = '0;
      if (RE)
      begin
         unique case (ADDR)
            dcf_pkg::OFS_STATUS:
            begin
               rdata_next[dcf_pkg::ST_EMPTY_N]  = flags_reg.empty_flag_n;
               rdata_next[dcf_pkg::ST_FULL_N]   = flags_reg.full_flag_n;
               rdata_next[dcf_pkg::ST_AEMPTY_N] = flags_reg.almost_empty_flag_n;
               rdata_next[dcf_pkg::ST_AFULL_N]  = flags_reg.almost_full_flag_n;
               rdata_next[dcf_pkg::ST_MODE_WE2] = mode_we2_reg;
            end
            dcf_pkg::OFS_EMPTY_OFF: rdata_next = widen({1'b0, eoff_reg});
            dcf_pkg::OFS_FULL_OFF:  rdata_next = widen({1'b0, foff_reg});
            dcf_pkg::OFS_IRQ_STAT:  rdata_next[dcf_pkg::IRQ_W-1:0] = istat_reg;
            dcf_pkg::OFS_IRQ_EN:    rdata_next[dcf_pkg::IRQ_W-1:0] = ien_reg;
            dcf_pkg::OFS_LEVEL:     rdata_next = widen(wlevel);
            default:                rdata_next = '0;
         endcase
      end

      q_oe_next = ~pins_s.output_enable_n;
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLK)
   begin
      mode_we2_reg <= mode_we2_next;
      q_oe_reg     <= q_oe_next;
      if (SRST)
      begin
         wptr_reg  <= '0;
         rptr_reg  <= '0;
         wseen_reg <= '0;
         rseen_reg <= '0;
         flags_reg <= '{almost_full_flag_n: 1'b1, almost_empty_flag_n: 1'b0,
                        full_flag_n: 1'b1, empty_flag_n: 1'b0};
         eoff_reg  <= dcf_pkg::OFFSET_RST[AW-1:0];
         foff_reg  <= dcf_pkg::OFFSET_RST[AW-1:0];
         ldsel_reg <= dcf_pkg::LD_EMPTY;
         istat_reg <= '0;
         ien_reg   <= dcf_pkg::IRQ_EN_RST;
         irq_reg   <= 1'b0;
         rdata_reg <= '0;
      end
      else
      begin
         wptr_reg  <= wptr_next;
         rptr_reg  <= rptr_next;
         wseen_reg <= wseen_next;
         rseen_reg <= rseen_next;
         flags_reg <= flags_next;
         eoff_reg  <= eoff_next;
         foff_reg  <= foff_next;
         ldsel_reg <= ldsel_next;
         istat_reg <= istat_next;
         ien_reg   <= ien_next;
         irq_reg   <= irq_next;
         rdata_reg <= rdata_next;
      end
   end

   // ==========================================================
   // storage; read data cleared by reset
   dcf_mem #(
      .W     (dcf_pkg::DATA_W),
      .DEPTH (DEPTH)
   ) u_mem (
      .clk     (CLK),
      .srst    (SRST),
      .wr_en   (wr_ok & ~SRST),
      .wr_addr (wptr_reg[AW-1:0]),
      .wr_data (pins_s.write_data_bus),
      .rd_en   (rd_ok & ~SRST),
      .rd_addr (rptr_reg[AW-1:0]),
      .rd_data (READ_DATA_BUS)
   );

   assign READ_DATA_BUS_OE    = q_oe_reg;
   assign EMPTY_FLAG_N        = flags_reg.empty_flag_n;
   assign FULL_FLAG_N         = flags_reg.full_flag_n;
   assign ALMOST_EMPTY_FLAG_N = flags_reg.almost_empty_flag_n;
   assign ALMOST_FULL_FLAG_N  = flags_reg.almost_full_flag_n;
   assign RDATA               = rdata_reg;
   assign IRQ                 = irq_reg;

endmodule

// ===== test/dcf_sva.sv
// concurrent checks on the fifo top ports
`timescale 1ns/1ps
module dcf_sva (
   input wire logic                       CLK,
   input wire logic                       SRST,
   input wire logic                       WRITE_ENABLE_FIRST_N,
   input wire logic                       WRITE_ENABLE_SECOND_OR_OFFSET_LOAD,
   input wire logic                       READ_ENABLE_FIRST_N,
   input wire logic                       READ_ENABLE_SECOND_N,
   input wire logic                       OUTPUT_ENABLE_N,
   input wire logic [dcf_pkg::DATA_W-1:0] READ_DATA_BUS,
   input wire logic                       READ_DATA_BUS_OE,
   input wire logic                       EMPTY_FLAG_N,
   input wire logic                       FULL_FLAG_N,
   input wire logic                       ALMOST_EMPTY_FLAG_N,
   input wire logic                       ALMOST_FULL_FLAG_N,
   input wire logic                       RE,
   input wire logic [31:0]                RDATA
);
   // ==========================================================
   // sequences
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   // six quiet samples cover the whole pin sync plus flag pipeline
   sequence s_full_idle;
      (READ_ENABLE_FIRST_N && !FULL_FLAG_N) [*6];
   endsequence
   sequence s_empty_idle;
      (WRITE_ENABLE_FIRST_N && !EMPTY_FLAG_N) [*6];
   endsequence
   // ==========================================================
   // properties
   a_reset_state: assert property ($fell(SRST) |->
      !EMPTY_FLAG_N && FULL_FLAG_N && !ALMOST_EMPTY_FLAG_N && ALMOST_FULL_FLAG_N && READ_DATA_BUS == 9'h000)
      else $error("state after reset wrong");
   a_oe_delay: assert property (READ_DATA_BUS_OE == !$past(OUTPUT_ENABLE_N, 3))
      else $error("output enable does not follow pin");
   a_empty_lift: assert property (!WRITE_ENABLE_FIRST_N && WRITE_ENABLE_SECOND_OR_OFFSET_LOAD &&
      !EMPTY_FLAG_N |-> ##[1:8] $rose(EMPTY_FLAG_N)) else $error("empty flag not lifted by write");
   a_full_free: assert property (!READ_ENABLE_FIRST_N && !READ_ENABLE_SECOND_N && WRITE_ENABLE_FIRST_N &&
      !FULL_FLAG_N |-> ##[1:8] $rose(FULL_FLAG_N)) else $error("full flag not freed by read");
   a_ae_with_e: assert property (!EMPTY_FLAG_N |-> !ALMOST_EMPTY_FLAG_N)
      else $error("almost empty high while empty");
   a_af_with_f: assert property (!FULL_FLAG_N |-> !ALMOST_FULL_FLAG_N)
      else $error("almost full high while full");
   a_empty_hold: assert property (s_empty_idle |=> !EMPTY_FLAG_N)
      else $error("empty flag lifted without write");
   a_full_hold: assert property (s_full_idle |=> !FULL_FLAG_N)
      else $error("full flag freed without read");
   a_rdata_idle: assert property (!$past(RE) |-> RDATA == 32'h0)
      else $error("read data outside read answer");
endmodule

bind dcf_top dcf_sva dcf_sva_i (
   .CLK                                (CLK),
   .SRST                               (SRST),
   .WRITE_ENABLE_FIRST_N               (WRITE_ENABLE_FIRST_N),
   .WRITE_ENABLE_SECOND_OR_OFFSET_LOAD (WRITE_ENABLE_SECOND_OR_OFFSET_LOAD),
   .READ_ENABLE_FIRST_N                (READ_ENABLE_FIRST_N),
   .READ_ENABLE_SECOND_N               (READ_ENABLE_SECOND_N),
   .OUTPUT_ENABLE_N                    (OUTPUT_ENABLE_N),
   .READ_DATA_BUS                      (READ_DATA_BUS),
   .READ_DATA_BUS_OE                   (READ_DATA_BUS_OE),
   .EMPTY_FLAG_N                       (EMPTY_FLAG_N),
   .FULL_FLAG_N                        (FULL_FLAG_N),
   .ALMOST_EMPTY_FLAG_N                (ALMOST_EMPTY_FLAG_N),
   .ALMOST_FULL_FLAG_N                 (ALMOST_FULL_FLAG_N),
   .RE                                 (RE),
   .RDATA                              (RDATA)
);

// ===== test/dcf_partner.sv
// writer and reader pin model facing the fifo pins
`timescale 1ns/1ps
module dcf_partner (
   input  wire logic                       clk,
   input  wire logic                       strap,
   input  wire logic                       wr_go,
   input  wire logic                       rd_go,
   input  wire logic                       oe_n,
   input  wire logic [dcf_pkg::DATA_W-1:0] word,
   output      dcf_pkg::dcf_pins_t         pins
);
   // ==========================================================
   // pin drive
   initial pins = '1;
   // clocks keep running through reset, so the model never pauses
   always @(posedge clk)
   begin
      pins.write_enable_first_n <= !wr_go;
      pins.write_enable_second_or_offset_load <= strap;
      pins.read_enable_first_n <= !rd_go;
      pins.read_enable_second_n <= !rd_go;
      pins.output_enable_n <= oe_n;
      // released data shows the inverse so a stale word never passes
      pins.write_data_bus <= wr_go ? word : ~pins.write_data_bus;
   end
endmodule

// ===== test/tb.sv
// self-checking bench for the fifo flag block
`timescale 1ns/1ps
module tb;
   localparam int      DEPTH = 16;
   logic               clk;
   logic               srst;
   logic               we;
   logic               re;
   logic               re_d;
   logic               strap;
   logic               wr_go;
   logic               rd_go;
   logic               oe_n;
   logic               mon_on;
   logic               rd_oe;
   logic               ef_n;
   logic               ff_n;
   logic               aef_n;
   logic               aff_n;
   logic               irq;
   logic [7:0]         addr;
   logic [31:0]        wdata;
   logic [31:0]        rdata;
   logic [31:0]        seed;
   logic [8:0]         word;
   logic [8:0]         rd_bus;
   logic [8:0]         last_q;
   logic [3:0]         idx;
   dcf_pkg::dcf_pins_t pins;
   int                 fails;
   int                 checked;
   int                 n;
   logic [31:0]        rq[$];
   logic [8:0]         dq[$];

   // ==========================================================
   // instances
   dcf_partner dcf_partner_i (.clk(clk), .strap(strap), .wr_go(wr_go), .rd_go(rd_go), .oe_n(oe_n),
      .word(word), .pins(pins));
   dcf_top #(.DEPTH(DEPTH)) dcf_top_i (.CLK(clk), .SRST(srst),
      .WRITE_ENABLE_FIRST_N(pins.write_enable_first_n),
      .WRITE_ENABLE_SECOND_OR_OFFSET_LOAD(pins.write_enable_second_or_offset_load),
      .READ_ENABLE_FIRST_N(pins.read_enable_first_n), .READ_ENABLE_SECOND_N(pins.read_enable_second_n),
      .OUTPUT_ENABLE_N(pins.output_enable_n), .WRITE_DATA_BUS(pins.write_data_bus),
      .READ_DATA_BUS(rd_bus), .READ_DATA_BUS_OE(rd_oe), .EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n),
      .ALMOST_EMPTY_FLAG_N(aef_n), .ALMOST_FULL_FLAG_N(aff_n), .ADDR(addr), .WDATA(wdata),
      .WE(we), .RE(re), .RDATA(rdata), .IRQ(irq));

   // ==========================================================
   // helpers
   initial
   begin
      clk = 1'h0;
      // one clock for writer and reader: zero skew, every crossing takes the late path
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      we <= 1'h1;
      @(posedge clk);
      we <= 1'h0;
      @(posedge clk);
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      addr <= a;
      re <= 1'h1;
      @(posedge clk);
      re <= 1'h0;
      @(posedge clk);
   endtask

   // k back-to-back words, each unique so the monitor sees every change
   task automatic wr_n(input int k);
      repeat (k)
      begin
         seed = xs(seed);
         idx++;
         word <= {1'h1, seed[3:0], idx};
         wr_go <= 1'h1;
         dq.push_back({1'h1, seed[3:0], idx});
         @(posedge clk);
      end
      wr_go <= 1'h0;
      @(posedge clk);
   endtask

   task automatic one_rd();
      rd_go <= 1'h1;
      @(posedge clk);
      rd_go <= 1'h0;
      @(posedge clk);
   endtask

   task automatic chk_flags(input int k);
      repeat (10) @(posedge clk);
      chk("flags", {k < 9, k > 7, k < DEPTH, k > 0}, {aff_n, aef_n, ff_n, ef_n});
   endtask

   task automatic do_reset(input logic s);
      strap <= s;
      srst <= 1'h1;
      repeat (6) @(posedge clk);
      srst <= 1'h0;
      repeat (2) @(posedge clk);
   endtask

   // ==========================================================
   // result monitor
   always @(posedge clk)
   begin
      re_d <= re;
      if (re_d)
         chk("register", rq.pop_front(), rdata);
      if (mon_on && rd_bus !== last_q)
         chk("read word", dq.pop_front(), rd_bus);
      last_q <= rd_bus;
   end

   // ==========================================================
   // main sequence
   initial
   begin
      {srst, we, re, re_d, strap, wr_go, rd_go, oe_n, mon_on, addr, wdata, word, idx} = '0;
      srst = 1'h1;
      seed = 32'hcaec;
      fails = 0;
      checked = 0;
      do_reset(1'h0);
      reg_rd(dcf_pkg::OFS_STATUS, 32'h0A);
      word <= 9'h003;
      wr_go <= 1'h1;
      @(posedge clk);
      word <= 9'h00C;
      @(posedge clk);
      wr_go <= 1'h0;
      repeat (6) @(posedge clk);
      reg_rd(dcf_pkg::OFS_EMPTY_OFF, 32'h3);
      reg_rd(dcf_pkg::OFS_FULL_OFF, 32'hC);
      do_reset(1'h1);
      mon_on <= 1'h1;
      reg_rd(dcf_pkg::OFS_STATUS, 32'h1A);
      reg_rd(dcf_pkg::OFS_EMPTY_OFF, 32'h7);
      reg_rd(dcf_pkg::OFS_FULL_OFF, 32'h7);
      oe_n <= 1'h1;
      repeat (5) @(posedge clk);
      chk("output enable", 1'h0, rd_oe);
      oe_n <= 1'h0;
      for (n = 1; n <= DEPTH; n++)
      begin
         wr_n(1);
         chk_flags(n);
      end
      // refused word carries no queue note, so any later sight of it fails
      word <= 9'h055;
      wr_go <= 1'h1;
      @(posedge clk);
      wr_go <= 1'h0;
      chk_flags(DEPTH);
      reg_rd(dcf_pkg::OFS_LEVEL, 32'h10);
      reg_rd(dcf_pkg::OFS_IRQ_STAT, 32'hD);
      chk("irq masked", 1'h0, irq);
      reg_wr(dcf_pkg::OFS_IRQ_EN, 32'h1);
      chk("irq raised", 1'h1, irq);
      reg_wr(dcf_pkg::OFS_IRQ_CLR, 32'hF);
      chk("irq cleared", 1'h0, irq);
      reg_wr(8'hFC, 32'hFFFF);
      reg_rd(8'hFC, 32'h0);
      for (n = DEPTH - 1; n >= 0; n--)
      begin
         one_rd();
         chk_flags(n);
      end
      one_rd();
      repeat (6) @(posedge clk);
      reg_rd(dcf_pkg::OFS_IRQ_STAT, 32'h2);
      chk("irq masked", 1'h0, irq);
      rd_go <= 1'h1;
      wr_n(1);
      for (n = 0; n < 20 && dq.size() != 0; n++)
         @(posedge clk);
      chk("first word wait", 1'h1, n < 12);
      if (dq.size() != 0)
         close_out();
      rd_go <= 1'h0;
      wr_n(4);
      repeat (8) @(posedge clk);
      rd_go <= 1'h1;
      repeat (4) @(posedge clk);
      rd_go <= 1'h0;
      // bus path to the offsets, the only way to set them while the shared pin is a second enable
      reg_wr(dcf_pkg::OFS_EMPTY_OFF, 32'h2);
      reg_wr(dcf_pkg::OFS_FULL_OFF, 32'h3);
      reg_rd(dcf_pkg::OFS_EMPTY_OFF, 32'h2);
      reg_rd(dcf_pkg::OFS_FULL_OFF, 32'h3);
      reg_rd(dcf_pkg::OFS_IRQ_EN, 32'h1);
      repeat (12) @(posedge clk);
      chk("words left", 32'h0, dq.size());
      close_out();
   end
endmodule
